// ===== mbs_pkg.sv
// Constants, carrier types and CRC helper for the serial slave command interpreter
package mbs_pkg;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_COIL = 8'h05;
    localparam logic [7:0] FC_WRITE = 8'h10;
    localparam logic [7:0] FC_IDENT = 8'h11;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VAL = 8'h03;
    localparam logic [7:0] BROADCAST = 8'h00;
    localparam logic [15:0] MAX_DATA_BYTES = 16'h00FA;
    localparam logic [15:0] MAX_REGS = 16'h007D;
    // Map window: message address 8000 lands on index 0
    localparam logic [15:0] REG_BASE = 16'h1F40;
    localparam int REG_AW = 8;
    localparam logic [16:0] REG_SPAN = 17'h00100;
    localparam int BUF_AW = 9;
    localparam logic [9:0] BUF_DEPTH = 10'h200;
    localparam logic [9:0] LEN_MIN = 10'h004;
    localparam logic [9:0] LEN_FIXED = 10'h008;
    localparam logic [9:0] LEN_IDENT = 10'h004;
    localparam logic [9:0] LEN_WRITE_OVH = 10'h009;
    localparam logic [8:0] WR_DATA_POS = 9'h007;
    localparam logic [15:0] COIL_ON = 16'hFF00;
    localparam logic [15:0] COIL_OFF = 16'h0000;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [7:0] STR_BASE_IDX = 8'h10;
    localparam logic [7:0] STR_WORDS = 8'h0A;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [15:0] LOG_EVENT_REG = 16'h0020;
    localparam logic [15:0] LOG_INTERVAL_REG = 16'h02BC;
    localparam logic [15:0] LOG_DAILY_REG = 16'h02BD;
    localparam logic [7:0] LOG_STAGE_IDX = 8'hE0;
    localparam logic [8:0] LOG_REC_WORDS = 9'h008;
    localparam logic [8:0] ID_WORDS = 9'h010;
    localparam logic [8:0] HDR_BYTES = 9'h003;
    localparam logic [8:0] ECHO_LEN = 9'h006;
    localparam logic [1:0] LOG_EVENT = 2'h0;
    localparam logic [1:0] LOG_INTERVAL = 2'h1;
    localparam logic [1:0] LOG_DAILY = 2'h2;
    localparam logic [15:0] PORT_FIRST = 16'h0000;
    localparam logic [15:0] PORT_SECOND = 16'h0001;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_DECODE = 6'b000010,
        S_WRITE = 6'b000100,
        S_PREP = 6'b001000,
        S_PUSH = 6'b010000,
        S_DRAIN = 6'b100000
    } mbs_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic eof;
        logic port;
    } mbs_rx_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } mbs_tx_t;

    typedef struct packed {
        logic [15:0] productCode;
        logic [15:0] tableNumber;
        logic [15:0] firmwareVersion;
        logic [15:0] manufactureDate;
        logic [15:0] salesDate;
        logic [15:0] serialHigh;
        logic [15:0] serialLow;
        logic [15:0] powerMode;
        logic [15:0] portMode;
        logic [15:0] portNodeAddress;
        logic [15:0] portBitRate;
        logic [15:0] responseTurnaroundDelay;
        logic [15:0] linkIdleTimeout;
        logic [15:0] realDate;
        logic [15:0] realTime;
    } mbs_ident_t;

    typedef struct packed {
        logic valid;
        logic [7:0] idx;
        logic [15:0] data;
    } mbs_fwwr_t;

    typedef struct packed {
        logic valid;
        logic [1:0] kind;
        logic [15:0] index;
    } mbs_logreq_t;

    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crcStep
endpackage : mbs_pkg

// ===== mbs_mem.sv
// Simple one-write one-read memory with registered read data
`timescale 1ns/10ps
module mbs_mem #(
    parameter int W = 8,
    parameter int AW = 9
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : mbs_mem

// ===== mbs_slave.sv
// Slave command interpreter: frame receive, decode, register access and reply
`timescale 1ns/10ps
module mbs_slave (
    input wire logic clk,
    input wire logic srst,
    input wire mbs_pkg::mbs_rx_t rx,
    input wire logic txReady,
    input wire mbs_pkg::mbs_ident_t ident,
    input wire mbs_pkg::mbs_fwwr_t fwWr,
    output mbs_pkg::mbs_tx_t tx,
    output logic eventAck,
    output mbs_pkg::mbs_logreq_t logReq,
    output logic busy
);
    mbs_pkg::mbs_state_t st_q, st_d;
    logic [9:0] rxCnt_q, rxCnt_d;
    logic [15:0] rxCrc_q, rxCrc_d;
    logic [5:0][7:0] hdr_q, hdr_d;
    logic [7:0] bc_q, bc_d;
    logic ovf_q, ovf_d;
    logic port_q, port_d;
    logic [7:0] fc_q, fc_d;
    logic excOn_q, excOn_d;
    logic [7:0] excCode_q, excCode_d;
    logic silent_q, silent_d;
    logic [8:0] txLen_q, txLen_d;
    logic [8:0] idx_q, idx_d;
    logic [15:0] txCrc_q, txCrc_d;
    logic [7:0] rdIdx_q, rdIdx_d;
    logic strEnd_q, strEnd_d;
    logic [8:0] wc_q, wc_d;
    logic [7:0] hi_q, hi_d;
    mbs_pkg::mbs_tx_t tx_q, tx_d;
    logic evt_q, evt_d;
    mbs_pkg::mbs_logreq_t log_q, log_d;
    logic busy_q, busy_d;

    logic bufWe;
    logic [7:0] bufQ;
    logic regWe;
    logic [7:0] regWaddr;
    logic [15:0] regWdata;
    logic [7:0] regRaddr;
    logic [15:0] regQ;
    logic [15:0] startAddr, qty, offs, coilVal;
    logic [16:0] endOffs;
    logic inRange, qtyBad;
    logic [8:0] dataPos;
    logic [7:0] regIdx, nextByte;
    logic [15:0] idWordVal;

    function automatic logic [15:0] idWord(input mbs_pkg::mbs_ident_t id, input logic [3:0] n, input logic p);
        logic [15:0] w;
        unique case (n)
            4'h0: w = id.productCode;
            4'h1: w = id.tableNumber;
            4'h2: w = id.firmwareVersion;
            4'h3: w = id.manufactureDate;
            4'h4: w = id.salesDate;
            4'h5: w = id.serialHigh;
            4'h6: w = id.serialLow;
            4'h7: w = id.powerMode;
            4'h8: w = p ? mbs_pkg::PORT_SECOND : mbs_pkg::PORT_FIRST;
            4'h9: w = id.portMode;
            4'hA: w = id.portNodeAddress;
            4'hB: w = id.portBitRate;
            4'hC: w = id.responseTurnaroundDelay;
            4'hD: w = id.linkIdleTimeout;
            4'hE: w = id.realDate;
            4'hF: w = id.realTime;
        endcase
        return w;
    endfunction : idWord

    // Raw frame kept until the CRC is known good, so a corrupt preset never lands
    mbs_mem #(.W(8), .AW(mbs_pkg::BUF_AW)) frameBuf (
        .clk(clk),
        .we(bufWe),
        .waddr(rxCnt_q[8:0]),
        .wdata(rx.data),
        .raddr(mbs_pkg::WR_DATA_POS + wc_q),
        .rdata(bufQ)
    );

    mbs_mem #(.W(16), .AW(mbs_pkg::REG_AW)) regBank (
        .clk(clk),
        .we(regWe),
        .waddr(regWaddr),
        .wdata(regWdata),
        .raddr(regRaddr),
        .rdata(regQ)
    );

    assign startAddr = {hdr_q[2], hdr_q[3]};
    assign qty = {hdr_q[4], hdr_q[5]};
    assign coilVal = qty;
    assign offs = startAddr - mbs_pkg::REG_BASE;
    assign endOffs = {1'b0, offs} + {1'b0, qty};
    assign inRange = (startAddr >= mbs_pkg::REG_BASE) && (endOffs <= mbs_pkg::REG_SPAN);
    assign qtyBad = (qty == 16'h0000) || (qty > mbs_pkg::MAX_REGS);
    assign dataPos = idx_q - mbs_pkg::HDR_BYTES;
    assign regIdx = rdIdx_q + dataPos[8:1];
    assign regRaddr = regIdx;
    assign bufWe = (st_q == mbs_pkg::S_IDLE) && rx.valid && (rxCnt_q < mbs_pkg::BUF_DEPTH);
    assign idWordVal = idWord(ident, dataPos[4:1], port_q);

    // Byte at the current reply position; high byte first on every data word, CRC low byte first
    always_comb begin
        nextByte = 8'h00;
        if (idx_q == 9'h000) begin
            nextByte = hdr_q[0];
        end else if (idx_q == 9'h001) begin
            nextByte = excOn_q ? (fc_q | mbs_pkg::EXC_FLAG) : fc_q;
        end else if (idx_q == txLen_q) begin
            nextByte = txCrc_q[7:0];
        end else if (idx_q > txLen_q) begin
            nextByte = txCrc_q[15:8];
        end else if (excOn_q) begin
            nextByte = excCode_q;
        end else if (fc_q == mbs_pkg::FC_COIL || fc_q == mbs_pkg::FC_WRITE) begin
            nextByte = hdr_q[idx_q[2:0]];
        end else if (idx_q == 9'h002) begin
            nextByte = 8'(txLen_q - mbs_pkg::HDR_BYTES);
        end else if (fc_q == mbs_pkg::FC_IDENT) begin
            nextByte = dataPos[0] ? idWordVal[7:0] : idWordVal[15:8];
        end else begin
            nextByte = dataPos[0] ? regQ[7:0] : regQ[15:8];
        end
    end

    always_comb begin
        st_d = st_q;
        rxCnt_d = rxCnt_q;
        rxCrc_d = rxCrc_q;
        hdr_d = hdr_q;
        bc_d = bc_q;
        ovf_d = ovf_q;
        port_d = port_q;
        fc_d = fc_q;
        excOn_d = excOn_q;
        excCode_d = excCode_q;
        silent_d = silent_q;
        txLen_d = txLen_q;
        idx_d = idx_q;
        txCrc_d = txCrc_q;
        rdIdx_d = rdIdx_q;
        strEnd_d = strEnd_q;
        wc_d = wc_q;
        hi_d = hi_q;
        tx_d = tx_q;
        evt_d = 1'b0;
        log_d = log_q;
        log_d.valid = 1'b0;
        regWe = fwWr.valid;
        regWaddr = fwWr.idx;
        regWdata = fwWr.data;
        if (tx_q.valid && txReady) begin
            tx_d.valid = 1'b0;
            tx_d.last = 1'b0;
        end
        unique case (st_q)
            mbs_pkg::S_IDLE: begin
                if (rx.valid) begin
                    rxCrc_d = mbs_pkg::crcStep(rxCrc_q, rx.data);
                    port_d = rx.port;
                    if (rxCnt_q < 10'h006) begin
                        hdr_d[rxCnt_q[2:0]] = rx.data;
                    end
                    if (rxCnt_q == 10'h006) begin
                        bc_d = rx.data;
                    end
                    if (rxCnt_q < mbs_pkg::BUF_DEPTH) begin
                        rxCnt_d = rxCnt_q + 10'h001;
                    end else begin
                        ovf_d = 1'b1;
                    end
                end
                if (rx.eof) begin
                    st_d = mbs_pkg::S_DECODE;
                end
            end
            mbs_pkg::S_DECODE: begin
                rxCnt_d = 10'h000;
                rxCrc_d = mbs_pkg::CRC_INIT;
                ovf_d = 1'b0;
                fc_d = hdr_q[1];
                excOn_d = 1'b0;
                excCode_d = mbs_pkg::EXC_FUNC;
                silent_d = (hdr_q[0] == mbs_pkg::BROADCAST);
                idx_d = 9'h000;
                txCrc_d = mbs_pkg::CRC_INIT;
                strEnd_d = 1'b0;
                wc_d = 9'h000;
                st_d = mbs_pkg::S_PREP;
                // Bad CRC, short, oversize or foreign frames are dropped without a reply
                if (rxCrc_q != 16'h0000 || rxCnt_q < mbs_pkg::LEN_MIN || ovf_q ||
                    (hdr_q[0] != ident.portNodeAddress[7:0] && hdr_q[0] != mbs_pkg::BROADCAST)) begin
                    st_d = mbs_pkg::S_IDLE;
                end else begin
                    unique case (hdr_q[1])
                        mbs_pkg::FC_READ: begin
                            if (rxCnt_q != mbs_pkg::LEN_FIXED) begin
                                st_d = mbs_pkg::S_IDLE;
                            end else if (startAddr == mbs_pkg::LOG_EVENT_REG ||
                                startAddr == mbs_pkg::LOG_INTERVAL_REG ||
                                startAddr == mbs_pkg::LOG_DAILY_REG) begin
                                // Record staged by the archive side at the stage index
                                log_d.valid = 1'b1;
                                log_d.kind = (startAddr == mbs_pkg::LOG_EVENT_REG) ? mbs_pkg::LOG_EVENT :
                                    (startAddr == mbs_pkg::LOG_INTERVAL_REG) ? mbs_pkg::LOG_INTERVAL :
                                    mbs_pkg::LOG_DAILY;
                                log_d.index = qty;
                                rdIdx_d = mbs_pkg::LOG_STAGE_IDX;
                                txLen_d = mbs_pkg::HDR_BYTES + {mbs_pkg::LOG_REC_WORDS[7:0], 1'b0};
                            end else if (qtyBad) begin
                                excOn_d = 1'b1;
                                excCode_d = mbs_pkg::EXC_VAL;
                            end else if (!inRange) begin
                                excOn_d = 1'b1;
                                excCode_d = mbs_pkg::EXC_ADDR;
                            end else begin
                                rdIdx_d = offs[7:0];
                                txLen_d = mbs_pkg::HDR_BYTES + {qty[7:0], 1'b0};
                            end
                        end
                        mbs_pkg::FC_WRITE: begin
                            if (rxCnt_q != mbs_pkg::LEN_WRITE_OVH + {2'b00, bc_q}) begin
                                st_d = mbs_pkg::S_IDLE;
                            end else if (qtyBad || {8'h00, bc_q} != {qty[14:0], 1'b0}) begin
                                excOn_d = 1'b1;
                                excCode_d = mbs_pkg::EXC_VAL;
                            end else if (!inRange) begin
                                excOn_d = 1'b1;
                                excCode_d = mbs_pkg::EXC_ADDR;
                            end else begin
                                rdIdx_d = offs[7:0];
                                txLen_d = mbs_pkg::ECHO_LEN;
                                st_d = mbs_pkg::S_WRITE;
                            end
                        end
                        mbs_pkg::FC_COIL: begin
                            if (rxCnt_q != mbs_pkg::LEN_FIXED) begin
                                st_d = mbs_pkg::S_IDLE;
                            end else if (coilVal != mbs_pkg::COIL_ON && coilVal != mbs_pkg::COIL_OFF) begin
                                excOn_d = 1'b1;
                                excCode_d = mbs_pkg::EXC_VAL;
                            end else begin
                                evt_d = (coilVal == mbs_pkg::COIL_ON);
                                txLen_d = mbs_pkg::ECHO_LEN;
                            end
                        end
                        mbs_pkg::FC_IDENT: begin
                            if (rxCnt_q != mbs_pkg::LEN_IDENT) begin
                                st_d = mbs_pkg::S_IDLE;
                            end else begin
                                txLen_d = mbs_pkg::HDR_BYTES + {mbs_pkg::ID_WORDS[7:0], 1'b0};
                            end
                        end
                        default: begin
                            excOn_d = 1'b1;
                            excCode_d = mbs_pkg::EXC_FUNC;
                        end
                    endcase
                    if (excOn_d) begin
                        txLen_d = mbs_pkg::HDR_BYTES;
                    end
                    if (silent_d && st_d == mbs_pkg::S_PREP) begin
                        st_d = mbs_pkg::S_IDLE;
                    end
                end
            end
            mbs_pkg::S_WRITE: begin
                // Buffer read lags one cycle, so position wc-1 is on bufQ now
                wc_d = wc_q + 9'h001;
                if (wc_q != 9'h000) begin
                    if (!wc_q[0]) begin
                        regWe = 1'b1;
                        regWaddr = rdIdx_q + wc_q[8:1] - 8'h01;
                        regWdata = {hi_q, bufQ};
                        if (wc_q[8:1] == qty[7:0]) begin
                            st_d = silent_q ? mbs_pkg::S_IDLE : mbs_pkg::S_PREP;
                        end
                    end else begin
                        hi_d = bufQ;
                    end
                end
            end
            mbs_pkg::S_PREP: begin
                st_d = mbs_pkg::S_PUSH;
            end
            mbs_pkg::S_PUSH: begin
                if (!tx_q.valid || txReady) begin
                    tx_d.valid = 1'b1;
                    tx_d.data = nextByte;
                    tx_d.last = (idx_q > txLen_q);
                    // Trailing characters of a packed string read as fill
                    if (fc_q == mbs_pkg::FC_READ && !excOn_q && idx_q > 9'h002 && idx_q < txLen_q &&
                        regIdx >= mbs_pkg::STR_BASE_IDX && regIdx < mbs_pkg::STR_BASE_IDX + mbs_pkg::STR_WORDS &&
                        (strEnd_q || nextByte == 8'h00)) begin
                        tx_d.data = mbs_pkg::FILL_BYTE;
                        strEnd_d = 1'b1;
                    end
                    // CRC must cover the byte actually sent, fill included
                    if (idx_q < txLen_q) begin
                        txCrc_d = mbs_pkg::crcStep(txCrc_q, tx_d.data);
                    end
                    idx_d = idx_q + 9'h001;
                    st_d = (idx_q > txLen_q) ? mbs_pkg::S_DRAIN : mbs_pkg::S_PREP;
                end
            end
            mbs_pkg::S_DRAIN: begin
                if (!tx_q.valid || txReady) begin
                    st_d = mbs_pkg::S_IDLE;
                end
            end
        endcase
        busy_d = (st_d != mbs_pkg::S_IDLE);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= mbs_pkg::S_IDLE;
            rxCnt_q <= 10'h000;
            rxCrc_q <= mbs_pkg::CRC_INIT;
            hdr_q <= '0;
            bc_q <= 8'h00;
            ovf_q <= 1'b0;
            port_q <= 1'b0;
            fc_q <= 8'h00;
            excOn_q <= 1'b0;
            excCode_q <= 8'h00;
            silent_q <= 1'b0;
            txLen_q <= 9'h000;
            idx_q <= 9'h000;
            txCrc_q <= mbs_pkg::CRC_INIT;
            rdIdx_q <= 8'h00;
            strEnd_q <= 1'b0;
            wc_q <= 9'h000;
            hi_q <= 8'h00;
            tx_q <= '0;
            evt_q <= 1'b0;
            log_q <= '0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rxCnt_q <= rxCnt_d;
            rxCrc_q <= rxCrc_d;
            hdr_q <= hdr_d;
            bc_q <= bc_d;
            ovf_q <= ovf_d;
            port_q <= port_d;
            fc_q <= fc_d;
            excOn_q <= excOn_d;
            excCode_q <= excCode_d;
            silent_q <= silent_d;
            txLen_q <= txLen_d;
            idx_q <= idx_d;
            txCrc_q <= txCrc_d;
            rdIdx_q <= rdIdx_d;
            strEnd_q <= strEnd_d;
            wc_q <= wc_d;
            hi_q <= hi_d;
            tx_q <= tx_d;
            evt_q <= evt_d;
            log_q <= log_d;
            busy_q <= busy_d;
        end
    end

    assign tx = tx_q;
    assign eventAck = evt_q;
    assign logReq = log_q;
    assign busy = busy_q;
endmodule : mbs_slave

// ===== mbs_slave_properties.sv
// Port-level properties of the slave command interpreter
`timescale 1ns/10ps
module mbs_slave_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic txReady,
    input wire mbs_pkg::mbs_tx_t tx,
    input wire logic eventAck,
    input wire mbs_pkg::mbs_logreq_t logReq,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_quiet: assert property ($fell(srst) |-> !tx.valid && !busy && !eventAck && !logReq.valid)
        else $error("outputs active after reset");
    a_tx_hold: assert property (tx.valid && !txReady |=> tx.valid && $stable(tx.data) && $stable(tx.last))
        else $error("reply byte dropped before accepted");
    a_tx_busy: assert property (tx.valid |-> busy)
        else $error("reply byte while idle");
    // A byte loaded and taken at once leaves a one-cycle gap before the next one
    a_byte_gap: assert property (tx.valid && txReady && (!$past(tx.valid) || $past(txReady)) |=> !tx.valid)
        else $error("next byte too early");
    a_last_done: assert property (tx.valid && tx.last && txReady |=> !busy && !tx.valid)
        else $error("busy held after final byte");
    a_reply_gap: assert property ($rose(busy) |-> !tx.valid [*2])
        else $error("reply before decode and prep");
    a_ack_pulse: assert property (eventAck |=> !eventAck)
        else $error("acknowledge longer than one cycle");
    a_ack_decode: assert property (eventAck |-> $past(busy) && !$past(busy, 2))
        else $error("acknowledge outside decode cycle");
    a_log_decode: assert property (logReq.valid |-> $past(busy) && !$past(busy, 2) && logReq.kind != 2'h3)
        else $error("archive request outside decode cycle");
    c_ack: cover property (eventAck);
    c_log: cover property (logReq.valid);
    c_last: cover property (tx.valid && tx.last && txReady);
endmodule : mbs_slave_properties

bind mbs_slave mbs_slave_properties i_mbs_slave_properties (.clk(clk), .srst(srst), .txReady(txReady),
    .tx(tx), .eventAck(eventAck), .logReq(logReq), .busy(busy));

// ===== mbs_master_model.sv
// Polling master model: sends framed requests and sinks the reply
`timescale 1ns/10ps
module mbs_master_model (
    input wire logic clk,
    input wire logic busy,
    input wire mbs_pkg::mbs_tx_t tx,
    output mbs_pkg::mbs_rx_t rx,
    output logic txReady
);
    logic [7:0] reply[$];
    logic slow = 1'b0;
    logic gotLast = 1'b0;
    initial rx = '0;
    initial txReady = 1'b1;
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction : crc16
    // Caller keeps quantities within limits except in refusal cases
    task automatic xfer(input logic [7:0] req[$], input logic port);
        logic [15:0] c;
        c = crc16(req);
        req.push_back(c[7:0]);
        req.push_back(c[15:8]);
        reply.delete();
        gotLast = 1'b0;
        foreach (req[i]) begin
            @(negedge clk);
            rx = '{valid: 1'b1, data: req[i], eof: 1'b0, port: port};
            @(negedge clk);
            rx.valid = 1'b0;
            rx.data = ~req[i]; // Released line must not keep the old byte
        end
        rx.eof = 1'b1;
        @(negedge clk);
        rx.eof = 1'b0;
        for (int n = 0; n < 4000 && !(gotLast && busy === 1'b0); n++)
            @(negedge clk);
    endtask : xfer
    // Slow mode stalls every other cycle to exercise the hold
    always @(negedge clk) txReady <= slow ? ~txReady : 1'b1;
    always @(posedge clk) begin
        if (tx.valid === 1'b1 && txReady === 1'b1) begin
            reply.push_back(tx.data);
            if (tx.last === 1'b1)
                gotLast = 1'b1;
        end
    end
endmodule : mbs_master_model

// ===== mbs_tb.sv
// Self-checking bench for the serial slave command interpreter
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] NODE = 8'h09;
    logic clk = 1'b0;
    logic srst = 1'b1;
    mbs_pkg::mbs_rx_t rx;
    logic txReady;
    mbs_pkg::mbs_ident_t ident = '0;
    mbs_pkg::mbs_fwwr_t fwWr = '0;
    mbs_pkg::mbs_tx_t tx;
    logic eventAck;
    mbs_pkg::mbs_logreq_t logReq;
    mbs_pkg::mbs_logreq_t lastLog = '0;
    logic busy;
    int n_mismatch = 0;
    int checks = 0;
    int nAck = 0;
    logic [7:0] want[$];
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (eventAck === 1'b1)
            nAck++;
        if (logReq.valid === 1'b1)
            lastLog = logReq;
    end
    mbs_slave i_mbs_slave (.clk(clk), .srst(srst), .rx(rx), .txReady(txReady), .ident(ident), .fwWr(fwWr),
        .tx(tx), .eventAck(eventAck), .logReq(logReq), .busy(busy));
    mbs_master_model i_mbs_master_model (.clk(clk), .busy(busy), .tx(tx), .rx(rx), .txReady(txReady));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic expect_reply(input logic [7:0] req[$], input logic port, input logic [7:0] exp[$]);
        logic [15:0] c;
        i_mbs_master_model.xfer(req, port);
        c = i_mbs_master_model.crc16(exp);
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
        check(16'(i_mbs_master_model.reply.size()), 16'(exp.size()));
        foreach (exp[i]) check({8'h00, i_mbs_master_model.reply[i]}, {8'h00, exp[i]});
    endtask : expect_reply
    task automatic bank_write(input logic [7:0] idx, input logic [15:0] data);
        @(negedge clk);
        fwWr = '{valid: 1'b1, idx: idx, data: data};
        @(negedge clk);
        fwWr.valid = 1'b0;
    endtask : bank_write
    task automatic t_write_read;
        bank_write(8'h00, 16'hA55A);
        expect_reply('{NODE, 8'h10, 8'h1F, 8'h41, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b0,
            '{NODE, 8'h10, 8'h1F, 8'h41, 8'h00, 8'h02});
        i_mbs_master_model.slow = 1'b1;
        expect_reply('{NODE, 8'h03, 8'h1F, 8'h40, 8'h00, 8'h03}, 1'b0,
            '{NODE, 8'h03, 8'h06, 8'hA5, 8'h5A, 8'h12, 8'h34, 8'h56, 8'h78});
        i_mbs_master_model.slow = 1'b0;
    endtask : t_write_read
    task automatic t_coil;
        expect_reply('{NODE, 8'h05, 8'h00, 8'h10, 8'hFF, 8'h00}, 1'b0,
            '{NODE, 8'h05, 8'h00, 8'h10, 8'hFF, 8'h00});
        check(16'(nAck), 16'h0001);
        expect_reply('{NODE, 8'h05, 8'h00, 8'h10, 8'h00, 8'h00}, 1'b0,
            '{NODE, 8'h05, 8'h00, 8'h10, 8'h00, 8'h00});
        check(16'(nAck), 16'h0001);
    endtask : t_coil
    task automatic t_ident;
        for (int p = 0; p < 2; p++) begin
            want = '{NODE, 8'h11, 8'h20};
            for (int k = 0; k < 15; k++) begin
                if (k == 8)
                    want = {want, 8'h00, 8'(p)};
                want = {want, 8'hC0 | 8'(k), 8'(k)};
            end
            expect_reply('{NODE, 8'h11}, 1'(p), want);
        end
    endtask : t_ident
    task automatic t_refuse;
        expect_reply('{NODE, 8'h07, 8'h1F, 8'h40, 8'h00, 8'h01}, 1'b0, '{NODE, 8'h87, 8'h01});
        expect_reply('{NODE, 8'h03, 8'h1F, 8'h40, 8'h00, 8'h7E}, 1'b0, '{NODE, 8'h83, 8'h03});
        expect_reply('{NODE, 8'h03, 8'h20, 8'h40, 8'h00, 8'h01}, 1'b0, '{NODE, 8'h83, 8'h02});
    endtask : t_refuse
    task automatic t_archive;
        want = '{NODE, 8'h03, 8'h10};
        for (int k = 0; k < 8; k++) begin
            bank_write(8'hE0 + 8'(k), {8'hE0, 8'(k)});
            want = {want, 8'hE0, 8'(k)};
        end
        // Interval kind, so a request that never fires cannot pass on the reset value
        expect_reply('{NODE, 8'h03, 8'h02, 8'hBC, 8'h00, 8'h05}, 1'b0, want);
        check({14'h0000, lastLog.kind}, 16'h0001);
        check(lastLog.index, 16'h0005);
    endtask : t_archive
    task automatic t_string;
        bank_write(8'h10, 16'h4142);
        bank_write(8'h11, 16'h4300);
        bank_write(8'h12, 16'h4445);
        expect_reply('{NODE, 8'h03, 8'h1F, 8'h50, 8'h00, 8'h03}, 1'b0,
            '{NODE, 8'h03, 8'h06, 8'h41, 8'h42, 8'h43, 8'hFF, 8'hFF, 8'hFF});
    endtask : t_string
    task automatic tally_and_finish;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        // Word k of the identity block is C k k; node address falls out as 09
        for (int k = 0; k < 15; k++)
            ident[239 - 16 * k -: 16] = {4'hC, 4'(k), 8'(k)};
        repeat (12) @(negedge clk);
        srst = 1'b0;
        t_write_read();
        t_coil();
        t_ident();
        t_refuse();
        t_archive();
        t_string();
        tally_and_finish();
    end
    initial begin
        #300us;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb
